// File: iscu_pkg.sv
// Constants and types of the instrument system command unit
`default_nettype none
package iscu_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GPIB   = 8'h04;
  localparam logic [7:0] OFS_LOCK   = 8'h08;
  localparam logic [7:0] OFS_QENAB  = 8'h0c;
  localparam logic [7:0] OFS_QEVT   = 8'h10;
  localparam logic [7:0] OFS_ERR    = 8'h14;
  localparam logic [7:0] OFS_ERRCNT = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1c;
  localparam logic [7:0] OFS_BAUD   = 8'h20;
  localparam logic [7:0] OFS_ALL    = 8'h40;
  // Control register fields
  localparam int B_ECHO   = 0;
  localparam int B_TXEN   = 1;
  localparam int B_SERIAL_FLOW_CONTROL   = 2;
  localparam int B_PROMPT = 3;
  localparam int B_LANG   = 4;
  localparam int B_BAUD   = 5;
  localparam logic [6:0] CTRL_RST  = 7'h12;
  localparam logic [4:0] GPIB_RST  = 5'h06;
  localparam logic [4:0] GPIB_MIN  = 5'h01;
  localparam logic [4:0] GPIB_MAX  = 5'h1e;
  localparam logic [5:0] QENAB_RST = 6'h00;
  // Error queue
  localparam int          ERR_DEPTH = 15;
  localparam logic [15:0] ERR_OVF   = 16'hfea2;
  localparam logic [15:0] ERR_NONE  = 16'h0000;
  // Serial characters
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_XON    = 8'h11;
  localparam logic [7:0] CH_XOFF   = 8'h13;
  localparam logic [7:0] CH_PROMPT = 8'h3e;
  // Baud rates and divisors
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_9600  = 9600;
  localparam int unsigned BAUD_4800  = 4800;
  localparam int unsigned BAUD_2400  = 2400;
  localparam int unsigned DIV_19200  = CLK_HZ / BAUD_19200;
  localparam int unsigned DIV_9600   = CLK_HZ / BAUD_9600;
  localparam int unsigned DIV_4800   = CLK_HZ / BAUD_4800;
  localparam int unsigned DIV_2400   = CLK_HZ / BAUD_2400;
  localparam int          DIV_W      = 17;
  localparam logic [2:0]  INIT_CYC   = 3'h4;
  typedef enum logic [2:0] {
    LK_LOCAL  = 3'b001,
    LK_REMOTE = 3'b010,
    LK_LLO    = 3'b100
  } iscu_lock_t;
endpackage : iscu_pkg
`default_nettype wire

// File: iscu_errq_if.sv
// Link between the command unit and its error queue
`timescale 1ns/1ps
`default_nettype none
interface iscu_errq_if;
  logic        push;
  logic [15:0] code;
  logic        pop;
  logic [15:0] head;
  logic [3:0]  count;
  logic [3:0]  peek_idx;
  logic [15:0] peek_code;
  modport ctl (output push, code, pop, peek_idx,
               input head, count, peek_code);
  modport q   (input push, code, pop, peek_idx,
               output head, count, peek_code);
endinterface : iscu_errq_if
`default_nettype wire

// File: iscu_errq.sv
// Fifteen-entry error queue with overflow marking
`timescale 1ns/1ps
`default_nettype none
module iscu_errq (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Queue port
  iscu_errq_if.q    e
);
  logic [15:0] q_r [0:iscu_pkg::ERR_DEPTH-1];
  logic [3:0]  cnt_r;
  logic        do_pop;
  logic [3:0]  cnt_mid;
  logic        full;
  logic [3:0]  wr_idx;
  logic [15:0] wr_val;

  assign do_pop  = e.pop && (cnt_r != 4'h0);
  assign cnt_mid = cnt_r - {3'h0, do_pop};
  assign full    = (cnt_mid == 4'(iscu_pkg::ERR_DEPTH));
  // Full queue keeps older entries; last slot becomes overflow code
  assign wr_idx  = full ? cnt_mid - 4'h1 : cnt_mid;
  assign wr_val  = full ? iscu_pkg::ERR_OVF : e.code;

  genvar i;
  generate
    for (i = 0; i < iscu_pkg::ERR_DEPTH; i++) begin : g_slot
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          q_r[i] <= iscu_pkg::ERR_NONE;
        end else if (e.push && wr_idx == 4'(i)) begin
          q_r[i] <= wr_val;
        end else if (do_pop) begin
          // Shift toward the head
          q_r[i] <= (i == iscu_pkg::ERR_DEPTH-1) ?
                    iscu_pkg::ERR_NONE : q_r[(i+1)%iscu_pkg::ERR_DEPTH];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_mid + {3'h0, e.push && !full};
    end
  end

  assign e.count     = cnt_r;
  assign e.head      = (cnt_r != 4'h0) ? q_r[0] : iscu_pkg::ERR_NONE;
  assign e.peek_code = (e.peek_idx < cnt_r) ?
                       q_r[e.peek_idx] : iscu_pkg::ERR_NONE;
endmodule : iscu_errq
`default_nettype wire

// File: iscu_top.sv
// Remote command unit: AHB registers, serial options, panel lockout
`timescale 1ns/1ps
`default_nettype none
// Function
// - Errors are queued first in, first out; oldest read first.
// - Each error read removes the returned entry.
// - Queue holds at most 15 errors; more is an overflow.
// - On overflow keep older errors; last entry becomes code -350.
// - Empty queue reads as code zero, meaning no error.
// - Code-only read returns just the next numeric code.
// - All-codes read lists up to 15 queued codes, zero if empty.
// - Echo returns each received character; off takes effect after LF. Code does not echo XON/XOFF while pacing is on.
// - Device reset command leaves the echo setting alone.
// - Echo, transmit, pacing and prompt settings read back as 01h/00h. Code returns them as bits 0 to 3 of one control word.
// - Transmit, once disabled, re-enables only by GPIB or power cycle.
// - Serial runs at selected 19200/9600/4800/2400 baud; reads back.
// - Pacing on applies XON/XOFF flow control; none applies none.
// - Prompt on sends a greater-than after each parsed command.
// - Lockout off: command gives remote; both knobs return to local.
// - Lockout on disables all panel controls and shows lockout code.
// - GPIB local-lockout message also enters local lockout.
// - Lockout ends only by lockout-off or power cycle with switch off.
// - Lockout read gives 1 when locked, 0 when local allowed.
// - Compatibility mode accepts legacy commands; standard rejects them.
// - Compatibility mode is the reset default.
// - Questionable enable mask reads back its current value.
// - Enabled questionable events OR into status summary bit 5.
module iscu_top #(
  parameter int unsigned DIV_19200 = iscu_pkg::DIV_19200,
  parameter int unsigned DIV_9600  = iscu_pkg::DIV_9600,
  parameter int unsigned DIV_4800  = iscu_pkg::DIV_4800,
  parameter int unsigned DIV_2400  = iscu_pkg::DIV_2400
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Command parser side
  input  wire logic        err_push,
  input  wire logic [15:0] err_code,
  input  wire logic        cmd_received,
  input  wire logic        cmd_parsed,
  input  wire logic        gpib_src,
  input  wire logic        gpib_llo,
  // Serial character stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  output logic             tx_valid,
  output logic [7:0]       tx_char,
  input  wire logic        tx_ready,
  output logic             baud_tick,
  // Front panel and switches
  input  wire logic        knobs_both,
  input  wire logic        dip5_off,
  input  wire logic        lockout_nv,
  output logic             front_panel_en,
  output logic             remote,
  output logic             front_panel_lockout,
  output logic             lockout_display_code,
  output logic             legacy_accept,
  output logic [4:0]       gpib_addr,
  // Questionable status
  input  wire logic [5:0]  ques_event,
  output logic             ques_summary
);
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  iscu_errq_if eq ();
  localparam int DIV_W_L = iscu_pkg::DIV_W;

  // Bus state
  logic        acc;
  logic        wr_ph_r;
  logic        rd_ph_r;
  logic [7:0]  a_r;
  logic        a_ok_r;
  // Settings
  logic [6:0]  ctrl_r;
  logic [4:0]  gpib_r;
  logic [5:0]  qenab_r;
  logic [5:0]  qevt_r;
  // Serial
  logic        echo_act_r;
  logic        echo_pend_r;
  logic [7:0]  echo_char_r;
  logic        prompt_pend_r;
  logic        paused_r;
  logic [DIV_W_L-1:0] bcnt_r;
  // Panel
  logic        knobs_m_r;
  logic        knobs_s_r;
  logic        knobs_d_r;
  logic        dip_m_r;
  logic        dip_s_r;
  logic [2:0]  init_r;
  iscu_pkg::iscu_lock_t lk_r;
  iscu_pkg::iscu_lock_t lk_nxt;

  // Address decode
  logic        wr_ctrl;
  logic        wr_gpib;
  logic        wr_lock;
  logic        wr_qenab;
  logic        rd_qevt;
  logic        rd_err;
  logic        sel_all;
  logic        tx_go;
  logic        rx_ctl;
  logic        knob_rise;
  logic        init_done;
  logic [DIV_W_L-1:0] div_sel;
  logic [31:0] baud_val;
  logic [31:0] rdata;
  logic [1:0]  bsel;

  assign acc = hsel && htrans[1] && hready && hsize == 3'h2;
  assign wr_ctrl  = wr_ph_r && a_ok_r && hit(a_r, iscu_pkg::OFS_CTRL);
  assign wr_gpib  = wr_ph_r && a_ok_r && hit(a_r, iscu_pkg::OFS_GPIB);
  assign wr_lock  = wr_ph_r && a_ok_r && hit(a_r, iscu_pkg::OFS_LOCK);
  assign wr_qenab = wr_ph_r && a_ok_r && hit(a_r, iscu_pkg::OFS_QENAB);
  assign rd_qevt  = rd_ph_r && a_ok_r && hit(a_r, iscu_pkg::OFS_QEVT);
  assign rd_err   = rd_ph_r && a_ok_r && hit(a_r, iscu_pkg::OFS_ERR);
  assign sel_all  = a_r >= iscu_pkg::OFS_ALL &&
                    a_r[7:6] == 2'h1 && a_r[5:2] != 4'hf;

  // Reads take one wait state so a preceding write has landed
  assign hreadyout = !rd_ph_r;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      a_r     <= 8'h00;
      a_ok_r  <= 1'b0;
      hrdata  <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_ph_r <= acc && hwrite;
        rd_ph_r <= acc && !hwrite;
        a_r     <= haddr[7:0];
        a_ok_r  <= haddr[31:8] == 24'h00_0000 && haddr[1:0] == 2'h0;
      end else begin
        rd_ph_r <= 1'b0;
      end
      if (rd_ph_r) begin
        hrdata <= rdata;
      end
    end
  end

  // Read mux; unmapped reads return zero
  assign bsel = ctrl_r[iscu_pkg::B_BAUD +: 2];
  assign baud_val = bsel == 2'h0 ? iscu_pkg::BAUD_19200 :
                    bsel == 2'h1 ? iscu_pkg::BAUD_9600 :
                    bsel == 2'h2 ? iscu_pkg::BAUD_4800 :
                    iscu_pkg::BAUD_2400;
  assign eq.peek_idx = a_r[5:2];
  assign rdata =
    !a_ok_r ? 32'h0000_0000 :
    hit(a_r, iscu_pkg::OFS_CTRL)  ? {25'h0, ctrl_r} :
    hit(a_r, iscu_pkg::OFS_GPIB)  ? {27'h0, gpib_r} :
    hit(a_r, iscu_pkg::OFS_LOCK)  ? {31'h0, lk_r == iscu_pkg::LK_LLO} :
    hit(a_r, iscu_pkg::OFS_QENAB) ? {26'h0, qenab_r} :
    hit(a_r, iscu_pkg::OFS_QEVT)  ? {26'h0, qevt_r} :
    hit(a_r, iscu_pkg::OFS_ERR)   ? {{16{eq.head[15]}}, eq.head} :
    hit(a_r, iscu_pkg::OFS_ERRCNT) ? {28'h0, eq.count} :
    hit(a_r, iscu_pkg::OFS_STAT)  ? {24'h0, paused_r, echo_act_r,
                                     ques_summary, 2'h0, lk_r} :
    hit(a_r, iscu_pkg::OFS_BAUD)  ? baud_val :
    sel_all ? {{16{eq.peek_code[15]}}, eq.peek_code} :
    32'h0000_0000;

  // Error queue
  assign eq.push = err_push;
  assign eq.code = err_code;
  assign eq.pop  = rd_err;

  iscu_errq u_errq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .e       (eq.q)
  );

  // Settings; only hresetn restores them, no command reset here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r  <= iscu_pkg::CTRL_RST;
      gpib_r  <= iscu_pkg::GPIB_RST;
      qenab_r <= iscu_pkg::QENAB_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[iscu_pkg::B_ECHO]   <= hwdata[iscu_pkg::B_ECHO];
        ctrl_r[iscu_pkg::B_SERIAL_FLOW_CONTROL]   <= hwdata[iscu_pkg::B_SERIAL_FLOW_CONTROL];
        ctrl_r[iscu_pkg::B_PROMPT] <= hwdata[iscu_pkg::B_PROMPT];
        ctrl_r[iscu_pkg::B_LANG]   <= hwdata[iscu_pkg::B_LANG];
        ctrl_r[iscu_pkg::B_BAUD +: 2] <=
          hwdata[iscu_pkg::B_BAUD +: 2];
        // Serial side cannot turn its own transmitter back on
        if (!hwdata[iscu_pkg::B_TXEN] || gpib_src) begin
          ctrl_r[iscu_pkg::B_TXEN] <= hwdata[iscu_pkg::B_TXEN];
        end
      end
      if (wr_gpib && hwdata[4:0] >= iscu_pkg::GPIB_MIN &&
          hwdata[4:0] <= iscu_pkg::GPIB_MAX) begin
        gpib_r <= hwdata[4:0];
      end
      if (wr_qenab) begin
        qenab_r <= hwdata[5:0];
      end
    end
  end

  // Questionable events latch; a new event beats the read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qevt_r <= 6'h00;
    end else begin
      qevt_r <= (rd_qevt ? 6'h00 : qevt_r) | ques_event;
    end
  end
  assign ques_summary = |(qevt_r & qenab_r);

  // Serial echo, prompt and pacing
  assign rx_ctl = ctrl_r[iscu_pkg::B_SERIAL_FLOW_CONTROL] &&
                  (rx_char == iscu_pkg::CH_XON ||
                   rx_char == iscu_pkg::CH_XOFF);
  assign tx_valid = ctrl_r[iscu_pkg::B_TXEN] && !paused_r &&
                    (echo_pend_r || prompt_pend_r);
  assign tx_char  = echo_pend_r ? echo_char_r : iscu_pkg::CH_PROMPT;
  assign tx_go    = tx_valid && tx_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      echo_act_r <= 1'b0;
      paused_r   <= 1'b0;
    end else begin
      if (wr_ctrl && hwdata[iscu_pkg::B_ECHO]) begin
        echo_act_r <= 1'b1;
      end else if (rx_valid && rx_char == iscu_pkg::CH_LF &&
                   !ctrl_r[iscu_pkg::B_ECHO]) begin
        echo_act_r <= 1'b0;
      end
      if (!ctrl_r[iscu_pkg::B_SERIAL_FLOW_CONTROL]) begin
        paused_r <= 1'b0;
      end else if (rx_valid && rx_char == iscu_pkg::CH_XOFF) begin
        paused_r <= 1'b1;
      end else if (rx_valid && rx_char == iscu_pkg::CH_XON) begin
        paused_r <= 1'b0;
      end
    end
  end

  // One character of holding each; a newer echo overwrites an old one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      echo_pend_r   <= 1'b0;
      echo_char_r   <= 8'h00;
      prompt_pend_r <= 1'b0;
    end else begin
      if (!ctrl_r[iscu_pkg::B_TXEN]) begin
        echo_pend_r <= 1'b0;
      end else if (rx_valid && echo_act_r && !rx_ctl) begin
        echo_pend_r <= 1'b1;
        echo_char_r <= rx_char;
      end else if (tx_go && echo_pend_r) begin
        echo_pend_r <= 1'b0;
      end
      if (!ctrl_r[iscu_pkg::B_TXEN]) begin
        prompt_pend_r <= 1'b0;
      end else if (cmd_parsed && ctrl_r[iscu_pkg::B_PROMPT]) begin
        prompt_pend_r <= 1'b1;
      end else if (tx_go && !echo_pend_r) begin
        prompt_pend_r <= 1'b0;
      end
    end
  end

  // Baud divider
  assign div_sel = bsel == 2'h0 ? DIV_W_L'(DIV_19200 - 1) :
                   bsel == 2'h1 ? DIV_W_L'(DIV_9600 - 1) :
                   bsel == 2'h2 ? DIV_W_L'(DIV_4800 - 1) :
                   DIV_W_L'(DIV_2400 - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_r    <= '0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= bcnt_r >= div_sel;
      bcnt_r    <= (bcnt_r >= div_sel) ? '0 : bcnt_r + 1'b1;
    end
  end

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      knobs_m_r <= 1'b0;
      knobs_s_r <= 1'b0;
      knobs_d_r <= 1'b0;
      dip_m_r   <= 1'b1;
      dip_s_r   <= 1'b1;
      init_r    <= 3'h0;
    end else begin
      knobs_m_r <= knobs_both;
      knobs_s_r <= knobs_m_r;
      knobs_d_r <= knobs_s_r;
      dip_m_r   <= dip5_off;
      dip_s_r   <= dip_m_r;
      if (!init_done) begin
        init_r <= init_r + 3'h1;
      end
    end
  end
  assign knob_rise = knobs_s_r && !knobs_d_r;
  assign init_done = init_r == iscu_pkg::INIT_CYC;

  // Lockout state machine
  always_comb begin
    lk_nxt = lk_r;
    case (lk_r)
      iscu_pkg::LK_LOCAL: begin
        // Power-up: retained lockout survives unless switch is off
        if (init_r == iscu_pkg::INIT_CYC - 3'h1 && !dip_s_r &&
            lockout_nv) begin
          lk_nxt = iscu_pkg::LK_LLO;
        end else if ((wr_lock && hwdata[0]) || gpib_llo) begin
          lk_nxt = iscu_pkg::LK_LLO;
        end else if (cmd_received) begin
          lk_nxt = iscu_pkg::LK_REMOTE;
        end
      end
      iscu_pkg::LK_REMOTE: begin
        if ((wr_lock && hwdata[0]) || gpib_llo) begin
          lk_nxt = iscu_pkg::LK_LLO;
        end else if (knob_rise) begin
          lk_nxt = iscu_pkg::LK_LOCAL;
        end
      end
      iscu_pkg::LK_LLO: begin
        // Knobs are ignored; only the lockout-off command leaves
        if (wr_lock && !hwdata[0]) begin
          lk_nxt = iscu_pkg::LK_REMOTE;
        end
      end
      default: lk_nxt = iscu_pkg::LK_LOCAL;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk_r <= iscu_pkg::LK_LOCAL;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  assign front_panel_en       = lk_r == iscu_pkg::LK_LOCAL;
  assign remote               = lk_r != iscu_pkg::LK_LOCAL;
  assign front_panel_lockout  = lk_r == iscu_pkg::LK_LLO;
  assign lockout_display_code = lk_r == iscu_pkg::LK_LLO;
  assign legacy_accept        = ctrl_r[iscu_pkg::B_LANG];
  assign gpib_addr            = gpib_r;
endmodule : iscu_top
`default_nettype wire

// File: iscu_top_fix_note_unused.sv
// Spare source file, no design unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: iscu_props.sv
// Port-level assertions of the command unit
`timescale 1ns/1ps
`default_nettype none
module iscu_props (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic [2:0] hsize,
  input wire logic       hready,
  input wire logic       hreadyout,
  // Events and status
  input wire logic       gpib_llo,
  input wire logic       cmd_received,
  input wire logic       cmd_parsed,
  input wire logic       knobs_both,
  input wire logic       rx_valid,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_char,
  input wire logic       tx_ready,
  input wire logic       baud_tick,
  input wire logic       front_panel_en,
  input wire logic       remote,
  input wire logic       front_panel_lockout,
  input wire logic       lockout_display_code,
  input wire logic       legacy_accept
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic acc = hsel && htrans[1] && hready && hsize == 3'h2;
  // No bus access and no competing character source
  wire logic quiet = !hsel && !rx_valid && !cmd_parsed;

  chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");
  chk_write_ready: assert property (acc && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_llo_enter: assert property (gpib_llo |=> front_panel_lockout)
    else $error("bus lockout message ignored");
  chk_llo_panel: assert property (front_panel_lockout |->
    lockout_display_code && !front_panel_en && remote)
    else $error("lockout state outputs wrong");
  chk_llo_knobs: assert property (front_panel_lockout && knobs_both && !hsel
    |=> front_panel_lockout)
    else $error("knobs left lockout");
  chk_remote_cmd: assert property (front_panel_en && cmd_received |=> remote)
    else $error("command did not give remote");
  chk_remote_panel: assert property (remote |-> !front_panel_en)
    else $error("panel enabled in remote");
  chk_echo_hold: assert property (quiet ##1 (quiet && tx_valid && !tx_ready)
    |=> tx_valid && $stable(tx_char))
    else $error("pending character dropped");
  chk_baud_pulse: assert property (baud_tick |=> !baud_tick)
    else $error("baud tick too long");
  chk_lang_reset: assert property ($rose(hresetn) |-> legacy_accept)
    else $error("legacy mode not default");

  cover property (gpib_llo);
  cover property (tx_valid && tx_ready);
  cover property (acc && !hwrite);
endmodule : iscu_props
bind iscu_top iscu_props u_iscu_props (.*);
`default_nettype wire

// File: iscu_host.sv
// Host controller model on the serial character stream
`timescale 1ns/1ps
`default_nettype none
module iscu_host (
  // Clock
  input  wire logic       hclk,
  // Serial stream
  output var logic        rx_valid,
  output var logic [7:0]  rx_char,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  output logic            tx_ready,
  // Slow host takes one char in four cycles
  input  wire logic       slow
);
  logic [7:0] got [$];
  logic [1:0] ph_r;
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'hff;
    ph_r = 2'h0;
  end
  always @(posedge hclk) ph_r <= ph_r + 2'h1;
  assign tx_ready = !slow || ph_r == 2'h3;
  always @(posedge hclk) if (tx_valid && tx_ready) got.push_back(tx_char);
  // Released line shows the inverse, not a stale copy
  task automatic send(input logic [7:0] c);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
    @(posedge hclk);
  endtask : send
endmodule : iscu_host
`default_nettype wire

// File: tb_instrument_system_command_unit.sv
// Self-checking bench of the instrument system command unit
`timescale 1ns/1ps
`default_nettype none
module tb_instrument_system_command_unit;
  localparam int unsigned DV [4] = '{8, 16, 32, 64};
  logic        hclk, hresetn, hsel, hwrite, err_push, cmd_received;
  logic        cmd_parsed, gpib_src, gpib_llo, knobs_both, dip5_off;
  logic        lockout_nv, slow, hreadyout, hresp, tx_valid, tx_ready;
  logic        baud_tick, front_panel_en, remote, front_panel_lockout;
  logic        lockout_display_code, legacy_accept, ques_summary, rx_valid;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] err_code;
  logic [7:0]  rx_char, tx_char;
  logic [4:0]  gpib_addr;
  logic [5:0]  ques_event;
  int          n_fail = 0;
  int          comparisons = 0;
  wire logic   hready = hreadyout;
  iscu_top #(.DIV_19200(DV[0]), .DIV_9600(DV[1]), .DIV_4800(DV[2]),
    .DIV_2400(DV[3])) u_iscu_top (.*);
  iscu_host u_iscu_host (.*);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic tmo(input bit t);
    if (t) begin
      n_fail++;
      complete_run;
    end
  endtask : tmo
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      tmo(++n > 40);
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : ahb
  task automatic rx_is(input logic [7:0] c);
    int n;
    n = 0;
    while (u_iscu_host.got.size() == 0 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    tmo(n == 60);
    chk(u_iscu_host.got.pop_front(), c);
  endtask : rx_is
  task automatic t_defaults;
    ahb(0, iscu_pkg::OFS_CTRL, 0);
    chk(rd, 32'h12);
    chk(legacy_accept, 1);
    ahb(0, iscu_pkg::OFS_GPIB, 0);
    chk(rd, 32'h6);
    ahb(0, 8'h3c, 0);
    chk(rd, 0);
  endtask : t_defaults
  task automatic t_errq;
    ahb(0, iscu_pkg::OFS_ERR, 0);
    chk(rd, 0);
    for (int i = 1; i <= 17; i++) begin
      err_push <= 1'b1;
      err_code <= 16'hff00 + 16'(i);
      @(posedge hclk);
    end
    err_push <= 1'b0;
    ahb(0, iscu_pkg::OFS_ERRCNT, 0);
    chk(rd, 15);
    ahb(0, 8'h78, 0);
    chk(rd, 32'hffff_fea2);
    ahb(0, iscu_pkg::OFS_ALL, 0);
    chk(rd, 32'hffff_ff01);
    for (int i = 1; i <= 14; i++) begin
      ahb(0, iscu_pkg::OFS_ERR, 0);
      chk(rd, 32'hffff_ff00 + 32'(i));
    end
    ahb(0, iscu_pkg::OFS_ERR, 0);
    chk(rd, 32'hffff_fea2);
    ahb(0, iscu_pkg::OFS_ALL, 0);
    chk(rd, 0);
  endtask : t_errq
  task automatic t_serial;
    slow <= 1'b1;
    ahb(1, iscu_pkg::OFS_CTRL, 32'h13);
    u_iscu_host.send(8'h41);
    rx_is(8'h41);
    slow <= 1'b0;
    ahb(1, iscu_pkg::OFS_CTRL, 32'h12);
    ahb(0, iscu_pkg::OFS_CTRL, 0);
    chk(rd, 32'h12);
    u_iscu_host.send(8'h42);
    u_iscu_host.send(iscu_pkg::CH_LF);
    u_iscu_host.send(8'h43);
    rx_is(8'h42);
    rx_is(iscu_pkg::CH_LF);
    repeat (20) @(posedge hclk);
    chk(u_iscu_host.got.size(), 0);
    ahb(1, iscu_pkg::OFS_CTRL, 32'h0e);
    u_iscu_host.send(iscu_pkg::CH_XOFF);
    cmd_parsed <= 1'b1;
    @(posedge hclk);
    cmd_parsed <= 1'b0;
    repeat (20) @(posedge hclk);
    chk(u_iscu_host.got.size(), 0);
    chk(legacy_accept, 0);
    u_iscu_host.send(iscu_pkg::CH_XON);
    rx_is(iscu_pkg::CH_PROMPT);
    ahb(1, iscu_pkg::OFS_CTRL, 32'h0a);
    u_iscu_host.send(iscu_pkg::CH_XOFF);
    cmd_parsed <= 1'b1;
    @(posedge hclk);
    cmd_parsed <= 1'b0;
    rx_is(iscu_pkg::CH_PROMPT);
    ahb(1, iscu_pkg::OFS_CTRL, 32'h08);
    ahb(1, iscu_pkg::OFS_CTRL, 32'h0a);
    ahb(0, iscu_pkg::OFS_CTRL, 0);
    chk(rd, 32'h08);
    gpib_src <= 1'b1;
    ahb(1, iscu_pkg::OFS_CTRL, 32'h1a);
    gpib_src <= 1'b0;
    ahb(0, iscu_pkg::OFS_CTRL, 0);
    chk(rd, 32'h1a);
  endtask : t_serial
  task automatic gap(output int n);
    int k;
    k = 0;
    while (baud_tick !== 1'b1 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (baud_tick !== 1'b1 && n < 200);
    tmo(k == 200 || n == 200);
  endtask : gap
  task automatic t_baud;
    int unsigned br [4];
    int n;
    br = '{iscu_pkg::BAUD_19200, iscu_pkg::BAUD_9600, iscu_pkg::BAUD_4800,
      iscu_pkg::BAUD_2400};
    for (int i = 0; i < 4; i++) begin
      ahb(1, iscu_pkg::OFS_CTRL, {25'h0, 2'(i), 5'h12});
      ahb(0, iscu_pkg::OFS_BAUD, 0);
      chk(rd, br[i]);
      gap(n);
      gap(n);
      chk(n, DV[i]);
    end
  endtask : t_baud
  task automatic t_gpib;
    logic [31:0] wv [4];
    logic [31:0] ex;
    wv = '{32'h1e, 32'h1f, 32'h00, 32'h01};
    ex = 32'h06;
    for (int i = 0; i < 4; i++) begin
      ahb(1, iscu_pkg::OFS_GPIB, wv[i]);
      if (wv[i] inside {[1:30]}) ex = wv[i];
      ahb(0, iscu_pkg::OFS_GPIB, 0);
      chk(rd, ex);
      chk({hresp, gpib_addr}, ex);
    end
  endtask : t_gpib
  task automatic t_ques;
    ahb(1, iscu_pkg::OFS_QENAB, 32'h09);
    ahb(0, iscu_pkg::OFS_QENAB, 0);
    chk(rd, 32'h09);
    for (int i = 0; i < 2; i++) begin
      ques_event <= i ? 6'h08 : 6'h02;
      @(posedge hclk);
      ques_event <= 6'h00;
      @(posedge hclk);
      chk(ques_summary, i);
    end
    ahb(0, iscu_pkg::OFS_QEVT, 0);
    chk(rd, 32'h0a);
    @(posedge hclk);
    chk(ques_summary, 0);
  endtask : t_ques
  task automatic knobs;
    knobs_both <= 1'b1;
    repeat (6) @(posedge hclk);
    knobs_both <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : knobs
  task automatic rst;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : rst
  task automatic t_lock;
    cmd_received <= 1'b1;
    @(posedge hclk);
    cmd_received <= 1'b0;
    @(posedge hclk);
    chk({remote, front_panel_en}, 2'b10);
    knobs;
    chk({remote, front_panel_en}, 2'b01);
    ahb(1, iscu_pkg::OFS_LOCK, 1);
    @(posedge hclk);
    chk({front_panel_lockout, lockout_display_code, front_panel_en}, 3'b110);
    knobs;
    ahb(0, iscu_pkg::OFS_LOCK, 0);
    chk(rd, 1);
    ahb(1, iscu_pkg::OFS_LOCK, 0);
    ahb(0, iscu_pkg::OFS_LOCK, 0);
    chk(rd, 0);
    gpib_llo <= 1'b1;
    @(posedge hclk);
    gpib_llo <= 1'b0;
    @(posedge hclk);
    chk(front_panel_lockout, 1);
    lockout_nv <= 1'b1;
    rst;
    chk(front_panel_lockout, 1);
    dip5_off <= 1'b1;
    rst;
    chk(front_panel_lockout, 0);
  endtask : t_lock
  initial begin
    {hresetn, hsel, hwrite, err_push, cmd_received, cmd_parsed} = 6'h00;
    {gpib_src, gpib_llo, knobs_both, dip5_off, lockout_nv, slow} = 6'h00;
    {htrans, haddr, hwdata, err_code, ques_event} = 88'h0;
    hsize = 3'h2;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults;
    t_errq;
    t_serial;
    t_baud;
    t_gpib;
    t_ques;
    t_lock;
    complete_run;
  end
endmodule : tb_instrument_system_command_unit
`default_nettype wire
